// ### hioc_pkg.sv
// Constants for the host I/O control register bank.
// Assumes a single 200 MHz system clock domain.
package hioc_pkg;

  // Register offsets within the eight-byte I/O window
  localparam logic [2:0] OFF_CARD_CONTROL      = 3'h0;
  localparam logic [2:0] OFF_MEMORY_BASE_MATCH = 3'h1;
  localparam logic [2:0] OFF_MEMORY_BANK_SEL   = 3'h2;
  localparam logic [2:0] OFF_WINDOW_SIZE_MASK  = 3'h3;
  localparam logic [2:0] OFF_HOST_INT_LINE     = 3'h4;
  localparam logic [2:0] OFF_INDICATOR_STATUS  = 3'h5;
  localparam logic [2:0] OFF_DEBUG_JTAG_CTRL   = 3'h6;
  localparam logic [2:0] OFF_CARD_TO_HOST_DATA = 3'h7;

  // Control register bit positions
  localparam int BIT_PROCESSOR_RUN    = 7;
  localparam int BIT_SHARED_MEM_EN    = 6;
  localparam int BIT_HOST_INT_EN      = 5;
  localparam int BIT_WDOG_TIMEOUT     = 4;
  localparam int BIT_TO_HOST_ONE      = 3;
  localparam int BIT_TO_HOST_ZERO     = 2;
  localparam int BIT_TO_PROC_ONE      = 1;
  localparam int BIT_TO_PROC_ZERO     = 0;

  // Reset values
  localparam logic [7:0] RST_CARD_CONTROL = 8'h00;
  localparam logic [7:0] RST_BASE_MATCH   = 8'h80;
  localparam logic [7:0] RST_BANK_SEL     = 8'h00;
  localparam logic [7:0] RST_WINDOW_MASK  = 8'h03;
  localparam logic [7:0] RST_INT_LINE     = 8'h00;
  localparam logic [7:0] RST_DEBUG        = 8'h00;
  localparam logic [7:0] RST_HOST_DATA    = 8'h00;

  // Writable bit masks
  localparam logic [7:0] MASK_BASE_MATCH  = 8'h7E;
  localparam logic [7:0] MASK_BANK_SEL    = 8'h3E;
  localparam logic [7:0] MASK_INT_LINE    = 8'h0F;

  // Shortest processor-run low time the host must keep, in ns
  localparam int RUN_LOW_MIN_NS = 50000;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int RUN_LOW_CYCLES =
    (RUN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host interrupt lines on the bus; the card can drive eight of them
  localparam int NUM_IRQ_LINES = 16;

endpackage

// ### hioc_regs.sv
// Host I/O control register bank of a fieldbus interface card.
// Assumes host strobes already synchronised to clk_sys, one cycle each.
`timescale 1ns/1ps
`default_nettype none

module hioc_regs
  import hioc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Switch-set base I/O address, pins
  input  wire logic [5:0]  base_switch,
  // Host I/O bus
  input  wire logic [10:0] io_addr,
  input  wire logic        io_read,
  input  wire logic        io_write,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_sel,
  // Host memory decode
  input  wire logic [19:12] mem_addr_hi,
  output logic             mem_hit,
  output logic      [17:13] mem_bank_addr,
  // Host interrupt lines
  output logic      [15:0] host_irq,
  // Card processor side
  input  wire logic        proc_set_host_one,
  input  wire logic        proc_set_host_zero,
  input  wire logic        proc_done_one,
  input  wire logic        proc_done_zero,
  input  wire logic        proc_data_we,
  input  wire logic [7:0]  proc_data,
  input  wire logic [3:0]  proc_led,
  input  wire logic        watchdog_expired,
  output logic             proc_halt,
  output logic             proc_irq_one,
  output logic             proc_irq_zero,
  output logic             sys_red,
  output logic             sys_green
);

  logic [5:0] sw_s1_q, sw_s2_q;
  logic [7:0] ctrl_q, match_q, bank_q, wsize_q, line_q, dbg_q, hdata_q;
  logic       wdog_q;
  logic [7:0] ctrl_d;

  // Switch pins cross from outside, two stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_s1_q <= 6'h00;
      sw_s2_q <= 6'h00;
    end else begin
      sw_s1_q <= base_switch;
      sw_s2_q <= sw_s1_q;
    end
  end

  // Base is 0x200 or 0x600 (switch bit 5) plus the low five switch bits times eight
  wire [10:0] base_addr = {sw_s2_q[5], 2'b10, sw_s2_q[4:0], 3'h0};
  wire        hit  = io_addr[10:3] == base_addr[10:3];
  wire [2:0]  off  = io_addr[2:0];
  wire        wr   = io_write && hit;
  wire        wr_c = wr && off == OFF_CARD_CONTROL;

  function automatic logic legal_size(input logic [7:0] v);
    legal_size = v == 8'h01 || v == 8'h03 || v == 8'h07 ||
                 v == 8'h0F || v == 8'h1F || v == 8'h3F;
  endfunction

  function automatic logic [3:0] line_num(input logic [3:0] c);
    unique case (c)
      4'h2, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF: line_num = c;
      default: line_num = 4'h0;
    endcase
  endfunction

  wire line_ok = line_num(line_q[3:0]) != 4'h0;
  wire running = ctrl_q[BIT_PROCESSOR_RUN];

  // Set wins over clear on every flag
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_c) begin
      ctrl_d[7:5] = io_wdata[7:5];
      ctrl_d[BIT_TO_HOST_ONE]  = ctrl_q[BIT_TO_HOST_ONE] &
                                 ~io_wdata[BIT_TO_HOST_ONE];
      ctrl_d[BIT_TO_HOST_ZERO] = ctrl_q[BIT_TO_HOST_ZERO] &
                                 ~io_wdata[BIT_TO_HOST_ZERO];
    end
    if (proc_done_one)
      ctrl_d[BIT_TO_PROC_ONE] = 1'b0;
    if (proc_done_zero)
      ctrl_d[BIT_TO_PROC_ZERO] = 1'b0;
    if (wr_c && io_wdata[BIT_TO_PROC_ONE])
      ctrl_d[BIT_TO_PROC_ONE] = 1'b1;
    if (wr_c && io_wdata[BIT_TO_PROC_ZERO])
      ctrl_d[BIT_TO_PROC_ZERO] = 1'b1;
    if (proc_set_host_one)
      ctrl_d[BIT_TO_HOST_ONE] = 1'b1;
    if (proc_set_host_zero)
      ctrl_d[BIT_TO_HOST_ZERO] = 1'b1;
    ctrl_d[BIT_WDOG_TIMEOUT] = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q  <= RST_CARD_CONTROL;
      wdog_q  <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      // Timeout latches only while running, cleared by run low
      if (!ctrl_d[BIT_PROCESSOR_RUN])
        wdog_q <= 1'b0;
      else if (watchdog_expired && running)
        wdog_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_q <= RST_BASE_MATCH;
      bank_q  <= RST_BANK_SEL;
      wsize_q <= RST_WINDOW_MASK;
      line_q  <= RST_INT_LINE;
      dbg_q   <= RST_DEBUG;
    end else if (wr) begin
      if (off == OFF_MEMORY_BASE_MATCH)
        match_q <= (io_wdata & MASK_BASE_MATCH) | RST_BASE_MATCH;
      if (off == OFF_MEMORY_BANK_SEL)
        bank_q <= io_wdata & MASK_BANK_SEL;
      // Illegal sizes are ignored so the window stays decodable
      if (off == OFF_WINDOW_SIZE_MASK && legal_size(io_wdata))
        wsize_q <= io_wdata;
      if (off == OFF_HOST_INT_LINE)
        line_q <= io_wdata & MASK_INT_LINE;
      if (off == OFF_DEBUG_JTAG_CTRL)
        dbg_q <= io_wdata;
    end
  end

  // Host never writes the data byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      hdata_q <= RST_HOST_DATA;
    else if (proc_data_we)
      hdata_q <= proc_data;
  end

  // Status reads one while halted for any reason
  wire halted = !running || wdog_q;
  wire [7:0] ctrl_rd = {ctrl_q[7:5], halted, ctrl_q[3:0]};
  wire [7:0] rd_mux =
    off == OFF_CARD_CONTROL      ? ctrl_rd :
    off == OFF_MEMORY_BASE_MATCH ? match_q :
    off == OFF_MEMORY_BANK_SEL   ? bank_q  :
    off == OFF_WINDOW_SIZE_MASK  ? wsize_q :
    off == OFF_HOST_INT_LINE     ? line_q  :
    off == OFF_INDICATOR_STATUS  ? {4'h0, proc_led} :
    off == OFF_DEBUG_JTAG_CTRL   ? dbg_q   : hdata_q;

  // Mask bits select which address bits compare
  wire [7:0] cmp = ~wsize_q;
  wire       mem_match =
    ((mem_addr_hi ^ match_q) & cmp) == 8'h00;
  wire flag_any = ctrl_q[BIT_TO_HOST_ONE] | ctrl_q[BIT_TO_HOST_ZERO];
  wire irq_on   = flag_any && ctrl_q[BIT_HOST_INT_EN] && line_ok;
  wire [15:0] irq_vec = irq_on ?
    16'h0001 << line_num(line_q[3:0]) : 16'h0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_rdata      <= 8'h00;
      io_sel        <= 1'b0;
      mem_hit       <= 1'b0;
      mem_bank_addr <= 5'h00;
      host_irq      <= 16'h0000;
      proc_halt     <= 1'b1;
      proc_irq_one  <= 1'b0;
      proc_irq_zero <= 1'b0;
      sys_red       <= 1'b1;
      sys_green     <= 1'b0;
    end else begin
      io_rdata      <= (io_read && hit) ? rd_mux : 8'h00;
      io_sel        <= hit && (io_read || io_write);
      mem_hit       <= mem_match && ctrl_q[BIT_SHARED_MEM_EN];
      // Bits masked by the size are forced to zero, not taken from the bank
      mem_bank_addr <= bank_q[5:1] & ~wsize_q[5:1];
      host_irq      <= irq_vec;
      proc_halt     <= halted;
      proc_irq_one  <= ctrl_q[BIT_TO_PROC_ONE];
      proc_irq_zero <= ctrl_q[BIT_TO_PROC_ZERO];
      sys_red       <= halted ? 1'b1 : proc_led[1];
      sys_green     <= halted ? 1'b0 : proc_led[0];
    end
  end

  a_halt_when_off: assert property (
    @(posedge clk_sys) disable iff (rst)
    !running |=> proc_halt && sys_red)
    else $error("processor not halted while run bit low");

  a_run_release: assert property (
    @(posedge clk_sys) disable iff (rst)
    running && !wdog_q |=> !proc_halt)
    else $error("processor halted while running");

  a_timeout_halt: assert property (
    @(posedge clk_sys) disable iff (rst)
    running && watchdog_expired ##1 running |=> proc_halt)
    else $error("timeout did not halt processor");

  a_mem_gate: assert property (
    @(posedge clk_sys) disable iff (rst)
    !ctrl_q[BIT_SHARED_MEM_EN] |=> !mem_hit)
    else $error("memory decoded while disabled");

  a_irq_line: assert property (
    @(posedge clk_sys) disable iff (rst)
    (host_irq != 16'h0000) |-> $past(flag_any && ctrl_q[BIT_HOST_INT_EN]))
    else $error("host interrupt without flag and enable");

  a_flag_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_c && io_wdata[BIT_TO_HOST_ZERO] && !proc_set_host_zero
      |=> !ctrl_q[BIT_TO_HOST_ZERO])
    else $error("to-host flag not cleared by write of one");

  a_proc_raise: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_c && io_wdata[BIT_TO_PROC_ONE] |=> ##1 proc_irq_one)
    else $error("processor flag not raised");

  a_data_ro: assert property (
    @(posedge clk_sys) disable iff (rst)
    !proc_data_we |=> $stable(hdata_q))
    else $error("data byte changed without processor write");

  a_bad_line: assert property (
    @(posedge clk_sys) disable iff (rst)
    !line_ok |=> host_irq == 16'h0000)
    else $error("interrupt driven on unsupported line");

  a_wdog_status: assert property (
    @(posedge clk_sys) disable iff (rst)
    wdog_q |-> running)
    else $error("timeout latched with run bit low");

  a_ctrl_reset: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> ctrl_q == RST_CARD_CONTROL)
    else $error("control register not zero after reset");

  a_flag_keeps: assert property (
    @(posedge clk_sys) disable iff (rst)
    proc_set_host_one |=> ctrl_q[BIT_TO_HOST_ONE])
    else $error("to-host flag not set by processor");

  a_zero_no_ack: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_c && !io_wdata[BIT_TO_HOST_ONE] && ctrl_q[BIT_TO_HOST_ONE]
      |=> ctrl_q[BIT_TO_HOST_ONE])
    else $error("to-host flag cleared by write of zero");

  a_zero_no_raise: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_c && !io_wdata[BIT_TO_PROC_ZERO] && !proc_done_zero
      |=> ctrl_q[BIT_TO_PROC_ZERO] == $past(ctrl_q[BIT_TO_PROC_ZERO]))
    else $error("processor flag changed by write of zero");

  a_proc_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    proc_done_zero && !(wr_c && io_wdata[BIT_TO_PROC_ZERO])
      |=> !ctrl_q[BIT_TO_PROC_ZERO])
    else $error("processor flag not cleared when serviced");

  a_status_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    io_read && hit && off == OFF_CARD_CONTROL && !running
      |=> io_rdata[BIT_WDOG_TIMEOUT])
    else $error("timeout status not read as one while halted");

  a_int_disable: assert property (
    @(posedge clk_sys) disable iff (rst)
    !ctrl_q[BIT_HOST_INT_EN] |=> host_irq == 16'h0000)
    else $error("host interrupt driven while disabled");

  a_io_window: assert property (
    @(posedge clk_sys) disable iff (rst)
    !hit |=> !io_sel && io_rdata == 8'h00)
    else $error("access answered outside the window");

endmodule

`default_nettype wire

// ### hioc_host_model.sv
// Host model: byte I/O reads and writes into the card window.
// Assumes the bench calls its tasks; strobes move at falling edge.
`timescale 1ns/1ps
`default_nettype none

module hioc_host_model
  import hioc_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Host I/O bus
  output logic      [10:0] io_addr,
  output logic             io_read,
  output logic             io_write,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata
);
  initial begin
    io_addr  = 11'h000;
    io_read  = 1'b0;
    io_write = 1'b0;
    io_wdata = 8'h00;
  end

  // One-cycle strobe, as the card takes it at the next rising edge
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr  = a;
    io_wdata = d;
    io_write = 1'b1;
    @(negedge clk_sys);
    io_write = 1'b0;
    io_wdata = ~d;
  endtask

  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_read = 1'b1;
    @(negedge clk_sys);
    d       = io_rdata;
    io_read = 1'b0;
  endtask

  // Shorter halts may leave the card processor half reset
  task automatic run_low(input logic [10:0] a);
    wr(a, 8'h00);
    repeat (RUN_LOW_CYCLES) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the host I/O control register bank.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import hioc_pkg::*;
  ;
  logic        clk_sys, rst, io_read, io_write, io_sel, mem_hit;
  logic        proc_halt, proc_irq_one, proc_irq_zero, sys_red, sys_green;
  logic [5:0]  base_switch, pp;
  logic [10:0] io_addr, base;
  logic [7:0]  io_wdata, io_rdata, rv, proc_data;
  logic [19:12] mem_addr_hi;
  logic [17:13] mem_bank_addr;
  logic [15:0] host_irq;
  logic [3:0]  proc_led;
  int          mismatches, num_checks, cycles;
  logic [7:0]  rst_tab [8] = '{8'h10, RST_BASE_MATCH, RST_BANK_SEL,
    RST_WINDOW_MASK, RST_INT_LINE, 8'h01, RST_DEBUG, RST_HOST_DATA};
  logic [7:0]  ws_tab [6] = '{8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
  logic [7:0]  code_tab [8] = '{8'h02, 8'h05, 8'h07, 8'h09,
    8'h0A, 8'h0B, 8'h0C, 8'h0F};

  hioc_regs u_dut (.clk_sys, .rst, .base_switch, .io_addr, .io_read,
    .io_write, .io_wdata, .io_rdata, .io_sel, .mem_addr_hi, .mem_hit,
    .mem_bank_addr, .host_irq, .proc_set_host_one(pp[0]),
    .proc_set_host_zero(pp[1]), .proc_done_one(pp[2]),
    .proc_done_zero(pp[3]), .proc_data_we(pp[4]), .proc_data, .proc_led,
    .watchdog_expired(pp[5]), .proc_halt, .proc_irq_one, .proc_irq_zero,
    .sys_red, .sys_green);

  hioc_host_model u_host (.clk_sys, .io_addr, .io_read, .io_write,
    .io_wdata, .io_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cut a hang short; covers the long run-low hold
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic pulse(input int k);
    @(negedge clk_sys);
    pp[k] = 1'b1;
    @(negedge clk_sys);
    pp[k] = 1'b0;
  endtask

  // Registered outputs trail the state by one cycle
  task automatic settle();
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic rdchk(input logic [2:0] o, input logic [7:0] e);
    u_host.rd(base + 11'(o), rv);
    chk("register", 16'(e), 16'(rv));
  endtask

  initial begin
    rst = 1'b1;
    base_switch = 6'h0A;
    pp = 6'h00;
    proc_data = 8'h5A;
    proc_led = 4'h1;
    mem_addr_hi = 8'h84;
    base = {base_switch[5], 2'b10, base_switch[4:0], 3'h0};
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) rdchk(3'(i), rst_tab[i]);
    chk("io_sel", 16'h0001, 16'(io_sel));
    chk("halt_red", 16'h0006, 16'({proc_halt, sys_red, sys_green}));
    u_host.rd(base + 11'h8, rv);
    chk("unmapped", 16'h0000, 16'({io_sel, rv}));
    u_host.wr(base, 8'h80);
    settle();
    chk("running", 16'h0001, 16'({proc_halt, sys_red, sys_green}));
    pulse(5);
    settle();
    chk("wdog", 16'h0006, 16'({proc_halt, sys_red, sys_green}));
    u_host.wr(base, 8'h80);
    rdchk(3'h0, 8'h90);
    u_host.run_low(base);
    rdchk(3'h0, 8'h10);
    u_host.wr(base, 8'hC0);
    settle();
    rdchk(3'h0, 8'hC0);
    chk("hit_16k", 16'h0000, 16'(mem_hit));
    for (int i = 0; i < 6; i++) begin
      u_host.wr(base + 11'h3, ws_tab[i]);
      rdchk(3'h3, ws_tab[i]);
    end
    u_host.wr(base + 11'h3, 8'h02);
    rdchk(3'h3, 8'h3F);
    chk("hit_256k", 16'h0001, 16'(mem_hit));
    u_host.wr(base + 11'h4, 8'h05);
    u_host.wr(base, 8'hA0);
    settle();
    chk("hit_off", 16'h0000, 16'(mem_hit));
    u_host.wr(base + 11'h2, 8'hFF);
    rdchk(3'h2, 8'h3E);
    chk("bank_256k", 16'h0000, 16'(mem_bank_addr));
    u_host.wr(base + 11'h3, 8'h03);
    settle();
    chk("bank_16k", 16'h001E, 16'(mem_bank_addr));
    pulse(0);
    settle();
    chk("irq_on", 16'h0020, host_irq);
    u_host.wr(base, 8'h80);
    settle();
    chk("irq_masked", 16'h0000, host_irq);
    rdchk(3'h0, 8'h88);
    u_host.wr(base, 8'hA0);
    settle();
    chk("irq_again", 16'h0020, host_irq);
    u_host.wr(base, 8'hA8);
    settle();
    chk("irq_ack", 16'h0000, host_irq);
    rdchk(3'h0, 8'hA0);
    pulse(1);
    for (int i = 0; i < 8; i++) begin
      u_host.wr(base + 11'h4, code_tab[i]);
      settle();
      chk("irq_line", 16'h0001 << code_tab[i], host_irq);
    end
    u_host.wr(base + 11'h4, 8'h03);
    settle();
    chk("irq_bad", 16'h0000, host_irq);
    u_host.wr(base, 8'h83);
    u_host.wr(base, 8'h80);
    settle();
    chk("proc_irq", 16'h0003, 16'({proc_irq_one, proc_irq_zero}));
    pulse(2);
    settle();
    chk("proc_done", 16'h0001, 16'({proc_irq_one, proc_irq_zero}));
    rdchk(3'h0, 8'h85);
    pulse(4);
    u_host.wr(base + 11'h7, 8'hFF);
    rdchk(3'h7, 8'h5A);
    results();
  end
endmodule
`default_nettype wire
